// ==== rtl/probe_latch_pkg.sv ====
// Shared types and constants for the touch-probe position latch
package probe_latch_pkg;
  localparam int VALUE_WIDTH = 32;
  localparam int TALLY_WIDTH = 16;
  localparam int FRAC_WIDTH = 8;
  localparam int STORE_DEPTH = 8;
  localparam int CLK_FREQ_HZ = 40000000;
  localparam logic [2:0] EDGE_UP_SELECT = 3'h2;
  localparam logic [2:0] EDGE_DOWN_SELECT = 3'h3;
  localparam logic [2:0] EDGE_ANY_SELECT = 3'h4;
  localparam logic [1:0] SINGLE_CAPTURE_MODE = 2'h0;
  localparam logic [1:0] COUNTED_CAPTURE_MODE = 2'h1;
  localparam logic [1:0] CIRCULAR_CAPTURE_MODE = 2'h2;
  localparam logic [TALLY_WIDTH-1:0] TALLY_RESET = 16'h0000;
  localparam logic [VALUE_WIDTH-1:0] VALUE_RESET = 32'h00000000;

  typedef struct packed {
    logic window_gate_enable;
    logic [VALUE_WIDTH-1:0] window_low_bound;
    logic [VALUE_WIDTH-1:0] window_high_bound;
  } window_cfg_type;

  typedef struct packed {
    logic [2:0] edge_select;
    logic [1:0] capture_mode;
    logic [TALLY_WIDTH-1:0] capture_limit;
    logic precise_time_enable;
  } capture_cfg_type;

  typedef enum logic [1:0] {
    IDLE_STATE = 2'b00,
    ARMED_STATE = 2'b01,
    DONE_STATE = 2'b10
  } latch_state_type;
endpackage

// ==== rtl/touch_probe_position_latch.sv ====
// Touch-probe latch: edge detect, window gate, estimate and store of the monitored quantity
`timescale 1ns/1ps
// Overview of operation
// - With precise timing off, detection code 2 captures on a rising edge, 3 on a falling edge and 4 on either edge; with it on, the station strobe triggers.
// - With the window gate on, each trigger's estimate is checked and out-of-window values are dropped.
// - When the low bound is not above the high bound, only values between them are accepted.
// - When the low bound exceeds the high bound, values at most the high bound or at least the low bound pass.
// - With the window gate off, every trigger is captured whatever the value.
// - Each accepted capture goes to the latest value, in modes 1 and 2 also to the store, and advances the tally.
// - The captured value is interpolated between cycle samples at the trigger instant.
// - With precise timing on, the trigger instant is the station-reported detection time.
// - With precise timing off, the trigger instant is the next operation cycle after the edge was seen.
// - Mode 0 captures once, mode 1 a configured number of times, mode 2 into a circular store.
// - Both window bounds are inclusive.
module touch_probe_position_latch
  import probe_latch_pkg::*;
#(
  parameter int WIDTH = VALUE_WIDTH,
  parameter int DEPTH = STORE_DEPTH,
  parameter int FRAC = FRAC_WIDTH
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cycle_tick,
  input wire logic execute,
  input wire logic trigger_in,
  input wire logic station_event,
  input wire logic [FRAC-1:0] station_fraction,
  input wire logic [WIDTH-1:0] monitored_quantity,
  input wire window_cfg_type window_cfg,
  input wire capture_cfg_type capture_cfg,
  output logic busy,
  output logic done,
  output logic capture_pulse,
  output logic [WIDTH-1:0] latest_capture_value,
  output logic [TALLY_WIDTH-1:0] capture_tally,
  output logic [$clog2(DEPTH)-1:0] store_write_index,
  output logic [DEPTH-1:0][WIDTH-1:0] capture_store
);
  localparam int IDX_W = $clog2(DEPTH);
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(DEPTH - 1);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("capture store depth must be a power of two");
    if (WIDTH != VALUE_WIDTH) $error("value width must match the package");
  end

  latch_state_type state;
  latch_state_type next_state;

  // Two-stage synchroniser for the pin-level trigger and station strobe
  logic trig_meta;
  logic trig_sync;
  logic trig_prev;
  logic stn_meta;
  logic stn_sync;
  logic stn_prev;
  logic [FRAC-1:0] stn_frac_meta;
  logic [FRAC-1:0] stn_frac_sync;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
      stn_meta <= 1'b0;
      stn_sync <= 1'b0;
      stn_frac_meta <= '0;
      stn_frac_sync <= '0;
    end else begin
      trig_meta <= trigger_in;
      trig_sync <= trig_meta;
      stn_meta <= station_event;
      stn_sync <= stn_meta;
      stn_frac_meta <= station_fraction;
      stn_frac_sync <= stn_frac_meta;
    end
  end

  // Samples of the quantity at the last two operation cycles
  logic [WIDTH-1:0] prev_sample;
  logic [WIDTH-1:0] curr_sample;
  logic pending_edge;

  wire logic rise = trig_sync & ~trig_prev;
  wire logic fall = ~trig_sync & trig_prev;
  wire logic edge_hit = (capture_cfg.edge_select == EDGE_UP_SELECT && rise)
                     || (capture_cfg.edge_select == EDGE_DOWN_SELECT && fall)
                     || (capture_cfg.edge_select == EDGE_ANY_SELECT && (rise || fall));
  wire logic stn_hit = stn_sync & ~stn_prev;

  // Trigger source: station strobe with its reported fraction, or the pin edge at cycle granularity
  wire logic raw_trigger = capture_cfg.precise_time_enable ? stn_hit : edge_hit;
  wire logic [FRAC-1:0] trig_frac = capture_cfg.precise_time_enable ? stn_frac_sync : '0;

  // The pin edge is resolved at the next operation cycle, so the estimate uses that cycle's sample
  wire logic eval_now = capture_cfg.precise_time_enable ? raw_trigger : (cycle_tick && (pending_edge || raw_trigger));
  wire logic [FRAC-1:0] eval_frac = capture_cfg.precise_time_enable ? trig_frac : {FRAC{1'b1}};

  logic [WIDTH-1:0] estimate;
  wire logic [WIDTH-1:0] est_prev = capture_cfg.precise_time_enable ? prev_sample : curr_sample;
  wire logic [WIDTH-1:0] est_curr = capture_cfg.precise_time_enable ? curr_sample : monitored_quantity;
  value_estimator #(
    .WIDTH(WIDTH),
    .FRAC(FRAC)
  ) u_estimator (
    .prev_value(est_prev),
    .curr_value(est_curr),
    .fraction(eval_frac),
    .estimate(estimate)
  );

  wire logic signed [WIDTH-1:0] est_s = $signed(estimate);
  wire logic signed [WIDTH-1:0] low_s = $signed(window_cfg.window_low_bound);
  wire logic signed [WIDTH-1:0] high_s = $signed(window_cfg.window_high_bound);
  wire logic wraps = low_s > high_s;
  wire logic in_plain = (est_s >= low_s) && (est_s <= high_s);
  wire logic in_wrap = (est_s <= high_s) || (est_s >= low_s);
  wire logic in_window = wraps ? in_wrap : in_plain;
  wire logic accept = (state == ARMED_STATE) && eval_now
                   && (!window_cfg.window_gate_enable || in_window);

  wire logic [TALLY_WIDTH-1:0] tally_inc = capture_tally + TALLY_WIDTH'(1);
  wire logic limit_hit = (capture_cfg.capture_mode == SINGLE_CAPTURE_MODE)
                      || (capture_cfg.capture_mode == COUNTED_CAPTURE_MODE
                          && tally_inc >= capture_cfg.capture_limit);
  wire logic use_store = capture_cfg.capture_mode != SINGLE_CAPTURE_MODE;
  wire logic [IDX_W-1:0] idx_inc = (store_write_index == IDX_LAST) ? '0 : store_write_index + IDX_W'(1);

  always_comb begin
    next_state = state;
    unique case (state)
      IDLE_STATE: begin
        if (execute) begin
          next_state = ARMED_STATE;
        end
      end
      ARMED_STATE: begin
        if (!execute) begin
          next_state = IDLE_STATE;
        end else if (accept && limit_hit) begin
          next_state = DONE_STATE;
        end
      end
      DONE_STATE: begin
        if (!execute) begin
          next_state = IDLE_STATE;
        end
      end
      default: begin
        next_state = IDLE_STATE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= IDLE_STATE;
      trig_prev <= 1'b0;
      stn_prev <= 1'b0;
      prev_sample <= VALUE_RESET;
      curr_sample <= VALUE_RESET;
      pending_edge <= 1'b0;
    end else begin
      state <= next_state;
      trig_prev <= trig_sync;
      stn_prev <= stn_sync;
      if (cycle_tick) begin
        prev_sample <= curr_sample;
        curr_sample <= monitored_quantity;
        pending_edge <= 1'b0;
      end else if (raw_trigger && !capture_cfg.precise_time_enable) begin
        pending_edge <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      capture_pulse <= 1'b0;
      latest_capture_value <= VALUE_RESET;
      capture_tally <= TALLY_RESET;
      store_write_index <= '0;
    end else begin
      busy <= (next_state == ARMED_STATE);
      done <= (next_state == DONE_STATE);
      capture_pulse <= accept;
      if (state == IDLE_STATE && execute) begin
        capture_tally <= TALLY_RESET;
        store_write_index <= '0;
      end else if (accept) begin
        latest_capture_value <= estimate;
        capture_tally <= tally_inc;
        if (use_store) begin
          store_write_index <= idx_inc;
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_store
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          capture_store[g] <= VALUE_RESET;
        end else if (accept && use_store && store_write_index == IDX_W'(g)) begin
          capture_store[g] <= estimate;
        end
      end
    end
  endgenerate

  a_capture_tally_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && !(state == IDLE_STATE) |=> capture_tally == $past(capture_tally) + TALLY_WIDTH'(1))
    else $error("tally did not advance on capture");
  a_latest_value_load: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept |=> latest_capture_value == $past(estimate))
    else $error("latest value not updated");
  a_window_reject: assert property (@(posedge core_clk) disable iff (!rst_n)
    window_cfg.window_gate_enable && !in_window |=> !capture_pulse)
    else $error("out-of-window capture");
  a_plain_window: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && window_cfg.window_gate_enable && !wraps
    |=> $signed(latest_capture_value) >= $signed($past(low_s))
        && $signed(latest_capture_value) <= $signed($past(high_s)))
    else $error("capture outside plain window");
  a_wrap_window: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && window_cfg.window_gate_enable && wraps
    |=> $signed(latest_capture_value) <= $signed($past(high_s))
        || $signed(latest_capture_value) >= $signed($past(low_s)))
    else $error("capture outside wrap window");
  a_gate_off_free: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == ARMED_STATE && eval_now && !window_cfg.window_gate_enable |-> accept)
    else $error("trigger lost with gate off");
  a_single_finish: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && execute && capture_cfg.capture_mode == SINGLE_CAPTURE_MODE |=> done && !busy)
    else $error("single mode did not finish");
  a_up_edge_only: assert property (@(posedge core_clk) disable iff (!rst_n)
    !capture_cfg.precise_time_enable && capture_cfg.edge_select == EDGE_UP_SELECT && fall
    && !cycle_tick && !pending_edge |=> !pending_edge)
    else $error("falling edge taken in rising mode");
  a_store_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && use_store && store_write_index == IDX_LAST && !(state == IDLE_STATE) |=> store_write_index == '0)
    else $error("store index did not wrap");
endmodule

// ==== rtl/value_estimator.sv ====
// Linear estimate of the monitored quantity between two cycle samples
`timescale 1ns/1ps
module value_estimator
  import probe_latch_pkg::*;
#(
  parameter int WIDTH = VALUE_WIDTH,
  parameter int FRAC = FRAC_WIDTH
) (
  input wire logic [WIDTH-1:0] prev_value,
  input wire logic [WIDTH-1:0] curr_value,
  input wire logic [FRAC-1:0] fraction,
  output logic [WIDTH-1:0] estimate
);
  initial begin
    if (WIDTH < 2 || FRAC < 1 || FRAC > 16) $error("value_estimator: bad widths");
  end

  // Signed step scaled by the fraction of the cycle elapsed at the trigger
  wire logic signed [WIDTH:0] step = $signed({curr_value[WIDTH-1], curr_value})
                                   - $signed({prev_value[WIDTH-1], prev_value});
  wire logic signed [WIDTH+FRAC+1:0] scaled = step * $signed({1'b0, fraction});
  wire logic signed [WIDTH+1:0] offset = scaled[WIDTH+FRAC+1:FRAC];
  wire logic signed [WIDTH+1:0] sum = $signed({{2{prev_value[WIDTH-1]}}, prev_value}) + offset;
  assign estimate = sum[WIDTH-1:0];
endmodule

// ==== testbench/station_model.sv ====
// Remote station model: trigger pin and precise detection strobe with its fraction
`timescale 1ns/1ps
module station_model
  import probe_latch_pkg::*;
(
  input wire logic core_clk,
  output logic trigger_in,
  output logic station_event,
  output logic [FRAC_WIDTH-1:0] station_fraction
);
  initial begin
    trigger_in = 1'b0;
    station_event = 1'b0;
    station_fraction = 8'h00;
  end
  // Pin edges go out unfiltered, one toggle at a falling clock edge
  task automatic toggle_pin();
    @(negedge core_clk);
    trigger_in = ~trigger_in;
  endtask
  // Fraction settles a clock ahead of the strobe and holds with it; afterwards the lines show its inverse
  task automatic station_hit(input logic [FRAC_WIDTH-1:0] frac);
    @(negedge core_clk);
    station_fraction = frac;
    @(negedge core_clk);
    station_event = 1'b1;
    repeat (4) @(negedge core_clk);
    station_event = 1'b0;
    station_fraction = ~frac;
  endtask
endmodule

// ==== testbench/tb_top.sv ====
// Testbench for the touch-probe position latch
`timescale 1ns/1ps
module tb_top;
  import probe_latch_pkg::*;
  logic core_clk, rst_n, execute, trigger_in, station_event, busy, done, capture_pulse;
  logic cycle_tick = 1'b0;
  logic [FRAC_WIDTH-1:0] station_fraction;
  logic [VALUE_WIDTH-1:0] monitored_quantity, latest_capture_value;
  window_cfg_type window_cfg;
  capture_cfg_type capture_cfg;
  logic [TALLY_WIDTH-1:0] capture_tally;
  logic [2:0] store_write_index;
  logic [2:0] tick_count = 3'h0;
  logic [STORE_DEPTH-1:0][VALUE_WIDTH-1:0] capture_store;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [2:0] edge_codes [3] = '{EDGE_UP_SELECT, EDGE_DOWN_SELECT, EDGE_ANY_SELECT};
  logic [31:0] win_vals [6] = '{32'h63, 32'h64, 32'hc8, 32'hc9, 32'h96, 32'hfffffffb};
  logic plain_ok [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  logic wrap_ok [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};

  touch_probe_position_latch i_dut (.core_clk, .rst_n, .cycle_tick, .execute, .trigger_in, .station_event,
    .station_fraction, .monitored_quantity, .window_cfg, .capture_cfg, .busy, .done, .capture_pulse,
    .latest_capture_value, .capture_tally, .store_write_index, .capture_store);
  station_model i_station (.core_clk, .trigger_in, .station_event, .station_fraction);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Operation cycle: one tick every eight clocks
  always @(negedge core_clk) begin
    tick_count <= tick_count + 3'h1;
    cycle_tick <= (tick_count == 3'h7);
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 12000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic arm(input logic [2:0] code, input logic [1:0] mode, input logic [15:0] limit,
                     input logic gate, input logic [31:0] lo, input logic [31:0] hi, input logic precise);
    @(negedge core_clk);
    execute = 1'b0;
    @(negedge core_clk);
    capture_cfg = {code, mode, limit, precise};
    window_cfg = {gate, lo, hi};
    execute = 1'b1;
    repeat (2) @(negedge core_clk);
  endtask
  // Holds the sample over two ticks, fires one pin edge and watches for a capture
  task automatic hit(input logic [31:0] value, input logic accept);
    logic seen;
    seen = 1'b0;
    monitored_quantity = value;
    repeat (17) @(negedge core_clk);
    i_station.toggle_pin();
    repeat (24) begin
      @(negedge core_clk);
      if (capture_pulse === 1'b1) seen = 1'b1;
    end
    check("capture", {31'h0, seen}, {31'h0, accept});
    if (accept) check("latest", latest_capture_value, value);
  endtask
  task automatic wait_tick();
    do @(negedge core_clk); while (cycle_tick !== 1'b1);
  endtask

  initial begin
    rst_n = 1'b0;
    execute = 1'b0;
    monitored_quantity = 32'h0;
    window_cfg = '0;
    capture_cfg = '0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    check("tally_reset", {16'h0, capture_tally}, 32'h0);
    foreach (edge_codes[i]) begin
      arm(edge_codes[i], CIRCULAR_CAPTURE_MODE, 16'h0001, 1'b0, 32'h0, 32'h0, 1'b0);
      hit(32'h10, edge_codes[i] != EDGE_DOWN_SELECT);
      hit(32'h20, edge_codes[i] != EDGE_UP_SELECT);
    end
    arm(EDGE_ANY_SELECT, CIRCULAR_CAPTURE_MODE, 16'h0001, 1'b1, 32'h64, 32'hc8, 1'b0);
    foreach (win_vals[i]) hit(win_vals[i], plain_ok[i]);
    check("plain_tally", {16'h0, capture_tally}, 32'h3);
    arm(EDGE_ANY_SELECT, CIRCULAR_CAPTURE_MODE, 16'h0001, 1'b1, 32'hc8, 32'h64, 1'b0);
    foreach (win_vals[i]) hit(win_vals[i], wrap_ok[i]);
    check("wrap_tally", {16'h0, capture_tally}, 32'h5);
    arm(EDGE_ANY_SELECT, SINGLE_CAPTURE_MODE, 16'h0001, 1'b0, 32'h0, 32'h0, 1'b0);
    hit(32'h30, 1'b1);
    hit(32'h40, 1'b0);
    check("single_done", {30'h0, done, busy}, 32'h2);
    arm(EDGE_ANY_SELECT, COUNTED_CAPTURE_MODE, 16'h0003, 1'b0, 32'h0, 32'h0, 1'b0);
    for (int i = 0; i < 4; i++) hit(32'h50 + i, i < 3);
    check("count_done", {30'h0, done, busy}, 32'h2);
    check("count_index", {29'h0, store_write_index}, 32'h3);
    for (int i = 0; i < 3; i++) check("count_store", capture_store[i], 32'h50 + i);
    arm(EDGE_ANY_SELECT, CIRCULAR_CAPTURE_MODE, 16'h0001, 1'b0, 32'h0, 32'h0, 1'b0);
    for (int i = 0; i < 9; i++) hit(32'h70 + i, 1'b1);
    check("ring_index", {29'h0, store_write_index}, 32'h1);
    check("ring_wrap", capture_store[0], 32'h78);
    check("ring_keep", capture_store[1], 32'h71);
    check("ring_tally", {16'h0, capture_tally}, 32'h9);
    check("ring_busy", {30'h0, done, busy}, 32'h1);
    arm(EDGE_ANY_SELECT, SINGLE_CAPTURE_MODE, 16'h0001, 1'b0, 32'h0, 32'h0, 1'b1);
    monitored_quantity = 32'h64;
    wait_tick();
    wait_tick();
    monitored_quantity = 32'h1f4;
    wait_tick();
    i_station.station_hit(8'h40);
    repeat (16) @(negedge core_clk);
    // A quarter of the way from 100 to 500
    check("precise_value", latest_capture_value, 32'hc8);
    check("precise_tally", {16'h0, capture_tally}, 32'h1);
    end_sim();
  end
endmodule
